// ### src/pipc_pkg.sv
// Shared constants and carriers for the per-port ingress policing control.
// Assumes one switch core clock; frame events come from same-clock logic.
package pipc_pkg;

   // Port population and addressing (index = byte address / 4)
   localparam int          NPORT      = 3;
   localparam int          NPRIO      = 8;
   localparam logic [3:0]  PORT_FIRST = 4'h1;
   localparam logic [13:0] ADDR_TOP   = 14'h0000;
   localparam logic [11:0] OFS_MAC0   = 12'h400;
   localparam logic [11:0] OFS_MAC1   = 12'h401;
   localparam logic [11:0] OFS_IRL    = 12'h403;
   localparam logic [11:0] OFS_PRIO0  = 12'h410;
   localparam logic [11:0] OFS_PRIO7  = 12'h417;
   localparam logic [8:0]  OFS_PRIO_HI = 9'h082;

   // Writable bits and reset values
   localparam logic [7:0] MAC0_WMASK = 8'h0B;
   localparam logic [7:0] MAC1_WMASK = 8'hBF;
   localparam logic [7:0] IRL_WMASK  = 8'h7F;
   localparam logic [7:0] REG_RST    = 8'h00;
   localparam logic [6:0] CODE_RST   = 7'h00;
   localparam logic [6:0] CODE_NOLIM = 7'h00;

   // Field positions
   localparam int MAC0_STORM = 1;
   localparam int MAC1_BP    = 3;
   localparam int MAC1_PASS  = 0;
   localparam int IRL_PORT   = 6;
   localparam int IRL_PPS    = 5;
   localparam int IRL_FC     = 4;
   localparam int IRL_MODE   = 2;
   localparam int IRL_IFG    = 1;
   localparam int IRL_PRE    = 0;

   // Frame class selections
   localparam logic [1:0] MODE_ALL   = 2'h0;
   localparam logic [1:0] MODE_FLOOD = 2'h1;
   localparam logic [1:0] MODE_MCAST = 2'h2;
   localparam logic [1:0] MODE_BCAST = 2'h3;

   // Byte overheads and rate arithmetic
   localparam logic [14:0] IFG_BYTES  = 15'h000C;
   localparam logic [14:0] PRE_BYTES  = 15'h0008;
   localparam int          BYTE_SHIFT = 3;
   localparam int          ACC_W      = 24;
   localparam logic [15:0] RATE_UNIT  = 16'h03E8;

   // Measurement window
   localparam int CLK_MHZ     = 125;
   localparam int WIN_TIME_US = 1000;
   localparam int WIN_CYCLES  = WIN_TIME_US * CLK_MHZ;

   typedef struct packed {
      logic        vld;
      logic [13:0] len;
      logic [2:0]  prio;
      logic        bcast;
      logic        mcast;
      logic        flood;
      logic        bad;
      logic        fc;
   } pipc_frm_t;

   typedef struct packed {
      logic vld;
      logic fwd;
      logic mirror_only;
      logic drop;
      logic over;
   } pipc_dec_t;

   typedef struct packed {
      logic full_duplex;
      logic pause_en;
      logic port_fc_en;
      logic congested;
      logic storm_over;
   } pipc_ctl_t;

   typedef struct packed {
      logic bp;
      logic pause;
      logic limit_fc;
   } pipc_req_t;

endpackage

// ### src/pipc_limiter.sv
// Per-port ingress rate meter over a fixed measurement window.
// Assumes frame events from same-clock logic, at most one per cycle.
`timescale 1ns/10ps
module pipc_limiter #(
   parameter int          WIN_CYCLES = pipc_pkg::WIN_CYCLES,
   parameter logic [15:0] RATE_UNIT  = pipc_pkg::RATE_UNIT
) (
   // Clock and reset
   input  wire logic                  clk,
   input  wire logic                  rst_n,
   input  wire logic                  ce,
   // Configuration
   input  wire logic [7:0]            irl,
   input  wire logic [7:0][6:0]       codes,
   // Frame event
   input  wire pipc_pkg::pipc_frm_t   frm,
   // Result
   output logic                       over_now,
   output logic                       fc_act
);
   localparam int WCW = $clog2(WIN_CYCLES);
   localparam int AW  = pipc_pkg::ACC_W;

   typedef struct packed {
      logic [pipc_pkg::NPRIO-1:0][AW-1:0] acc;
      logic [WCW-1:0]                     win;
      logic                               fc;
   } pipc_lim_st_t;

   pipc_lim_st_t st_ff;
   pipc_lim_st_t nxt_st;

   logic          counted;
   logic [2:0]    idx;
   logic [14:0]   bytes;
   logic [AW-1:0] amount;
   logic [AW-1:0] limit;
   logic [AW:0]   total;

   always_comb begin
      nxt_st = st_ff;
      case (irl[pipc_pkg::IRL_MODE +: 2])
         pipc_pkg::MODE_ALL:   counted = 1'b1;
         pipc_pkg::MODE_FLOOD: counted = frm.bcast | frm.mcast | frm.flood;
         pipc_pkg::MODE_MCAST: counted = frm.bcast | frm.mcast;
         pipc_pkg::MODE_BCAST: counted = frm.bcast;
         default:              counted = 1'b1;
      endcase
      // Port basis meters everything in slot zero
      idx = irl[pipc_pkg::IRL_PORT] ? 3'h0 : frm.prio;
      bytes = {1'b0, frm.len};
      if (irl[pipc_pkg::IRL_IFG]) begin
         bytes = bytes + pipc_pkg::IFG_BYTES;
      end
      if (irl[pipc_pkg::IRL_PRE] && !irl[pipc_pkg::IRL_PPS]) begin
         bytes = bytes + pipc_pkg::PRE_BYTES;
      end
      if (irl[pipc_pkg::IRL_PPS]) begin
         amount = AW'(1);
      end else begin
         amount = AW'({bytes, {pipc_pkg::BYTE_SHIFT{1'b0}}});
      end
      // Widen first: a 7-bit code times the unit overflows 16 bits
      limit = AW'(codes[idx]) * AW'(RATE_UNIT);
      // Window end opens a fresh budget; a frame then counts into it
      if (st_ff.win == WCW'(WIN_CYCLES - 1)) begin
         nxt_st.win = '0;
         nxt_st.acc = '0;
         nxt_st.fc  = 1'b0;
      end else begin
         nxt_st.win = st_ff.win + WCW'(1);
      end
      total    = {1'b0, nxt_st.acc[idx]} + {1'b0, amount};
      over_now = frm.vld && counted && (codes[idx] != pipc_pkg::CODE_NOLIM)
                 && (total > {1'b0, limit});
      if (frm.vld && counted && !over_now) begin
         nxt_st.acc[idx] = total[AW-1:0];
      end
      // Overrun beats the window clear in the same cycle
      if (over_now) begin
         nxt_st.fc = 1'b1;
      end
      fc_act = st_ff.fc;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_ff <= '0;
      end else if (ce) begin
         st_ff <= nxt_st;
      end
   end

endmodule // pipc_limiter

// ### src/pipc_top.sv
// Three-port ingress policing control with APB register access.
// Assumes frame events and port status come from same-clock switch logic.
`timescale 1ns/10ps
module pipc_top #(
   parameter int          WIN_CYCLES = pipc_pkg::WIN_CYCLES,
   parameter logic [15:0] RATE_UNIT  = pipc_pkg::RATE_UNIT
) (
   // Clock, reset, enable
   input  wire logic                                  pclk,
   input  wire logic                                  presetn,
   input  wire logic                                  pce,
   // APB slave
   input  wire logic                                  psel,
   input  wire logic                                  penable,
   input  wire logic                                  pwrite,
   input  wire logic [31:0]                           paddr,
   input  wire logic [31:0]                           pwdata,
   output logic [31:0]                                prdata,
   output logic                                       pready,
   output logic                                       pslverr,
   // Switch-wide flow control frame filtering
   input  wire logic                                  fc_filter,
   // Per-port frame events and status
   input  wire pipc_pkg::pipc_frm_t [pipc_pkg::NPORT-1:0] frm,
   input  wire pipc_pkg::pipc_ctl_t [pipc_pkg::NPORT-1:0] ctl,
   // Per-port decisions and flow requests
   output pipc_pkg::pipc_dec_t [pipc_pkg::NPORT-1:0]      dec,
   output pipc_pkg::pipc_req_t [pipc_pkg::NPORT-1:0]      req
);
   localparam int NP = pipc_pkg::NPORT;
   localparam int NQ = pipc_pkg::NPRIO;

   typedef struct packed {
      logic [7:0]                     prdata;
      logic                           err;
      logic                           lat;
      logic [NP-1:0][7:0]             mac0;
      logic [NP-1:0][7:0]             mac1;
      logic [NP-1:0][7:0]             irl;
      logic [NP-1:0][NQ-1:0][6:0]     shadow;
      logic [NP-1:0][NQ-1:0][6:0]     active;
      pipc_pkg::pipc_dec_t [NP-1:0]   dec;
      pipc_pkg::pipc_req_t [NP-1:0]   req;
   } pipc_st_t;

   pipc_st_t st_ff;
   pipc_st_t nxt_st;

   logic [NP-1:0] over_now;
   logic [NP-1:0] fc_act;

   // Decoded access
   logic [15:0] idx;
   logic [3:0]  a_port;
   logic [11:0] a_ofs;
   logic        a_top_ok;
   logic        setup;
   logic        wr_take;

   assign idx      = paddr[17:2];
   assign a_port   = idx[15:12];
   assign a_ofs    = idx[11:0];
   assign a_top_ok = (paddr[31:18] == pipc_pkg::ADDR_TOP) &&
                     (paddr[1:0] == 2'h0);
   assign setup    = psel && !st_ff.lat;
   assign wr_take  = psel && penable && pwrite && pready;

   // Stall while frozen; ready only once read data and error are latched
   assign pready  = pce && st_ff.lat;
   assign prdata  = {24'h000000, st_ff.prdata};
   assign pslverr = st_ff.err;
   assign dec     = st_ff.dec;
   assign req     = st_ff.req;

   // One meter per port
   genvar gp;
   generate
      for (gp = 0; gp < NP; gp++) begin : g_port
         pipc_limiter #(
            .WIN_CYCLES (WIN_CYCLES),
            .RATE_UNIT  (RATE_UNIT)
         ) u_lim (
            .clk      (pclk),
            .rst_n    (presetn),
            .ce       (pce),
            .irl      (st_ff.irl[gp]),
            .codes    (st_ff.active[gp]),
            .frm      (frm[gp]),
            .over_now (over_now[gp]),
            .fc_act   (fc_act[gp])
         );
      end
   endgenerate

   always_comb begin
      logic       hit;
      logic [7:0] rd;
      logic [1:0] p;
      logic [2:0] q;
      logic       lim_fc;
      hit    = 1'b0;
      rd     = 8'h00;
      p      = 2'h0;
      q      = a_ofs[2:0];
      lim_fc = 1'b0;
      nxt_st = st_ff;

      // Address decode; ports are numbered from one
      for (int i = 0; i < NP; i++) begin
         if (a_top_ok && (a_port == pipc_pkg::PORT_FIRST + 4'(i))) begin
            p = 2'(i);
            if ((a_ofs == pipc_pkg::OFS_MAC0) ||
                (a_ofs == pipc_pkg::OFS_MAC1) ||
                (a_ofs == pipc_pkg::OFS_IRL) ||
                ((a_ofs >= pipc_pkg::OFS_PRIO0) &&
                 (a_ofs <= pipc_pkg::OFS_PRIO7))) begin
               hit = 1'b1;
            end
         end
      end
      case (a_ofs)
         pipc_pkg::OFS_MAC0: rd = st_ff.mac0[p];
         pipc_pkg::OFS_MAC1: rd = st_ff.mac1[p];
         pipc_pkg::OFS_IRL:  rd = st_ff.irl[p];
         default:            rd = {1'b0, st_ff.shadow[p][q]};
      endcase

      // Latched once per transfer, late if pce was low in the setup cycle
      if (setup) begin
         nxt_st.prdata = hit && !pwrite ? rd : 8'h00;
         nxt_st.err    = !hit;
         nxt_st.lat    = 1'b1;
      end
      if (psel && penable && pready) begin
         nxt_st.lat = 1'b0;
      end

      if (wr_take && hit) begin
         case (a_ofs)
            pipc_pkg::OFS_MAC0: begin
               nxt_st.mac0[p] = (pwdata[7:0] & pipc_pkg::MAC0_WMASK) |
                                (st_ff.mac0[p] & ~pipc_pkg::MAC0_WMASK);
            end
            pipc_pkg::OFS_MAC1: begin
               nxt_st.mac1[p] = (pwdata[7:0] & pipc_pkg::MAC1_WMASK) |
                                (st_ff.mac1[p] & ~pipc_pkg::MAC1_WMASK);
            end
            pipc_pkg::OFS_IRL: begin
               nxt_st.irl[p] = pwdata[7:0] & pipc_pkg::IRL_WMASK;
            end
            default: begin
               nxt_st.shadow[p][q] = pwdata[6:0];
               // Staging keeps a partly written code set from metering
               if (a_ofs == pipc_pkg::OFS_PRIO7) begin
                  nxt_st.active[p] = nxt_st.shadow[p];
               end
            end
         endcase
      end

      // Frame decisions and flow requests, one port at a time
      for (int i = 0; i < NP; i++) begin
         nxt_st.dec[i]     = '0;
         nxt_st.dec[i].vld = frm[i].vld;
         if (frm[i].vld) begin
            if (frm[i].fc && fc_filter) begin
               nxt_st.dec[i].drop = 1'b1;
            end else if (frm[i].bad) begin
               if (st_ff.mac1[i][pipc_pkg::MAC1_PASS]) begin
                  nxt_st.dec[i].mirror_only = 1'b1;
               end else begin
                  nxt_st.dec[i].drop = 1'b1;
               end
            end else if (frm[i].bcast && ctl[i].storm_over &&
                         st_ff.mac0[i][pipc_pkg::MAC0_STORM]) begin
               nxt_st.dec[i].drop = 1'b1;
            end else if (over_now[i]) begin
               nxt_st.dec[i].drop = 1'b1;
            end else begin
               nxt_st.dec[i].fwd = 1'b1;
            end
            nxt_st.dec[i].over = over_now[i];
         end
         // Needs both the limiter bit and the port's own enable
         lim_fc = fc_act[i] && st_ff.irl[i][pipc_pkg::IRL_FC] &&
                  ctl[i].port_fc_en;
         nxt_st.req[i].limit_fc = lim_fc;
         nxt_st.req[i].bp = !ctl[i].full_duplex &&
                            st_ff.mac1[i][pipc_pkg::MAC1_BP] &&
                            (ctl[i].congested || lim_fc);
         nxt_st.req[i].pause = ctl[i].full_duplex && ctl[i].pause_en &&
                               (ctl[i].congested || lim_fc);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff <= '0;
      end else if (pce) begin
         st_ff <= nxt_st;
      end
   end

endmodule // pipc_top

// ### test/pipc_sva.sv
// Port assertions for the ingress policing control.
// Assumes one clock domain; switch port 1 (index 0) is watched.
`timescale 1ns/10ps
module pipc_sva (
   // Clock, reset, enable
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        pce,
   // APB
   input wire logic        psel,
   input wire logic        penable,
   input wire logic [31:0] paddr,
   input wire logic        pslverr,
   input wire logic        pready,
   // Frames and requests
   input wire logic        fc_filter,
   input wire pipc_pkg::pipc_frm_t [pipc_pkg::NPORT-1:0] frm,
   input wire pipc_pkg::pipc_ctl_t [pipc_pkg::NPORT-1:0] ctl,
   input wire pipc_pkg::pipc_dec_t [pipc_pkg::NPORT-1:0] dec,
   input wire pipc_pkg::pipc_req_t [pipc_pkg::NPORT-1:0] req
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   AST_BAD_NOFWD:
      assert property (frm[0].vld && pce && frm[0].bad
         |=> dec[0].vld && !dec[0].fwd) else $error("bad frame forwarded");
   AST_ONE_HOT:
      assert property (dec[0].vld |->
         $onehot({dec[0].fwd, dec[0].mirror_only, dec[0].drop}))
         else $error("decision not one-hot");
   AST_FC_DROP:
      assert property (frm[0].vld && pce && frm[0].fc && fc_filter
         |=> dec[0].drop) else $error("filtered fc frame kept");
   AST_NO_STORM:
      assert property (frm[0].vld && pce && !frm[0].bcast && !frm[0].bad
         && !frm[0].fc |=> dec[0].drop == dec[0].over)
         else $error("non-broadcast dropped without overrun");
   AST_BP_HALF:
      assert property (req[0].bp |-> !$past(ctl[0].full_duplex))
         else $error("back pressure in full duplex");
   AST_PAUSE_FULL:
      assert property (req[0].pause |->
         $past(ctl[0].full_duplex && ctl[0].pause_en))
         else $error("pause without full duplex enable");
   AST_LIMIT_FC:
      assert property (req[0].limit_fc |-> $past(ctl[0].port_fc_en))
         else $error("limiter flow control without port enable");
   AST_PORT3_DEC:
      assert property (frm[2].vld && pce |=> dec[2].vld)
         else $error("port 3 frame not decided");
   AST_MISALIGN:
      assert property (psel && penable && pready && paddr[1:0] != 2'h0
         |-> pslverr)
         else $error("misaligned access accepted");
   COV_MIRROR: cover property (dec[0].vld && dec[0].mirror_only);
   COV_LIMIT_FC: cover property (req[0].limit_fc);
   COV_BP: cover property (req[0].bp);
   COV_SLVERR: cover property (psel && penable && pslverr);
endmodule // pipc_sva

// ### test/pipc_top_bench.sv
// Self-checking bench for the three-port policing control.
// Assumes pce high until the frozen-block check at the end, and a shortened limiter window.
`timescale 1ns/10ps
module pipc_top_bench;
   localparam int          WIN = 1000;
   localparam logic [15:0] RU  = 16'h0040;
   localparam logic [11:0] OFS [3] = '{pipc_pkg::OFS_MAC0,
      pipc_pkg::OFS_MAC1, pipc_pkg::OFS_IRL};
   localparam logic [7:0]  MSK [3] = '{pipc_pkg::MAC0_WMASK,
      pipc_pkg::MAC1_WMASK, pipc_pkg::IRL_WMASK};
   localparam logic [31:0] BAD [4] = '{32'h0000_5008, 32'h0000_1000,
      32'h0000_5001, 32'h0004_5000};
   // {mac0, mac1, filter, storm, class bits, expected fwd/mirror/drop}
   localparam logic [31:0] TBL [8] = '{32'h0001_0012, 32'h0000_0011,
      32'h0001_1009, 32'h0001_000C, 32'h0200_0181, 32'h0000_0184,
      32'h0200_0084, 32'h0200_0144};
   localparam logic [4:0]  CK [4] = '{5'h00, 5'h04, 5'h08, 5'h10};
   logic        pclk, presetn, pce, psel, penable, pwrite;
   logic        pready, pslverr, fc_filter, er;
   logic [31:0] paddr, pwdata, prdata, rd, seed, t;
   logic [13:0] l;
   int          n_mismatch, num_checks, n;
   pipc_pkg::pipc_frm_t [pipc_pkg::NPORT-1:0] frm;
   pipc_pkg::pipc_ctl_t [pipc_pkg::NPORT-1:0] ctl;
   pipc_pkg::pipc_dec_t [pipc_pkg::NPORT-1:0] dec;
   pipc_pkg::pipc_req_t [pipc_pkg::NPORT-1:0] req;

   pipc_top #(.WIN_CYCLES(WIN), .RATE_UNIT(RU)) uut (.pclk(pclk),
      .presetn(presetn), .pce(pce), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .fc_filter(fc_filter),
      .frm(frm), .ctl(ctl), .dec(dec), .req(req));

   initial pclk = 1'b0;
   always #4 pclk = ~pclk;

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   function automatic logic [31:0] ad(input int p, input logic [11:0] o);
      return {14'h0, 4'(p), o, 2'h0};
   endfunction
   function automatic pipc_pkg::pipc_frm_t mk(input logic [13:0] b,
      input logic [2:0] p, input logic [4:0] k);
      return '{1'b1, b, p, k[4], k[3], k[2], k[1], k[0]};
   endfunction
   // Frames passed before overrun: limit over metered amount
   function automatic int cnt(input logic [7:0] c, input int q,
      input int b);
      int a;
      a = 8 * (b + (c[1] ? int'(pipc_pkg::IFG_BYTES) : 0)
         + (c[0] && !c[5] ? int'(pipc_pkg::PRE_BYTES) : 0));
      if (c[5])
         a = 1;
      return q * int'(RU) / a;
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [31:0] a,
      input logic [7:0] d);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      if (k >= 50) begin
         n_mismatch++;
         tally_and_finish();
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] o, input logic [7:0] d);
      apb(1'b1, ad(1, o), d);
   endtask
   task automatic fr(input int i, input pipc_pkg::pipc_frm_t f);
      @(posedge pclk);
      frm[i] <= f;
      @(posedge pclk);
      frm[i].vld <= 1'b0;
      #1;
   endtask
   // Ends on a window start, so the next burst sees a clear meter
   task automatic burst(input pipc_pkg::pipc_frm_t f, input int e);
      int k;
      n = 0;
      k = 0;
      do begin
         fr(0, f);
         n += int'(dec[0].fwd === 1'b1);
         k++;
      end while (dec[0].over !== 1'b1 && k < 300);
      if (dec[0].over !== 1'b1) begin
         n_mismatch++;
         tally_and_finish();
      end
      if (e >= 0)
         chk(32'(n), 32'(e));
      repeat (2) @(posedge pclk);
      #1;
      chk(32'(req[0].limit_fc), 32'h1);
      k = 0;
      while (req[0].limit_fc !== 1'b0 && k < 3 * WIN) begin
         @(posedge pclk);
         #1;
         k++;
      end
      if (k >= 3 * WIN) begin
         n_mismatch++;
         tally_and_finish();
      end
   endtask

   initial begin
      pce = 1'b1;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 32'h0;
      pwdata = 32'h0;
      fc_filter = 1'b0;
      frm = '0;
      ctl = '0;
      n_mismatch = 0;
      num_checks = 0;
      seed = 32'h0000_0011;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      for (int p = 1; p <= 3; p++) begin
         for (int r = 0; r < 3; r++) begin
            apb(1'b0, ad(p, OFS[r]), 8'h00);
            chk(rd, 32'h0);
            seed = xs(seed);
            apb(1'b1, ad(p, OFS[r]), seed[7:0]);
            apb(1'b0, ad(p, OFS[r]), 8'h00);
            chk(rd, {24'h0, seed[7:0] & MSK[r]});
         end
      end
      foreach (BAD[j]) begin
         apb(1'b1, BAD[j], 8'hFF);
         chk(32'(er), 32'h1);
      end
      foreach (TBL[j]) begin
         t = TBL[j];
         seed = xs(seed);
         wr(pipc_pkg::OFS_MAC0, t[31:24]);
         wr(pipc_pkg::OFS_MAC1, t[23:16]);
         fc_filter <= t[12];
         ctl[0].storm_over <= t[8];
         fr(0, mk(14'h0040 + 14'(seed[5:0]), 3'h0, t[7:3]));
         chk(32'({dec[0].fwd, dec[0].mirror_only, dec[0].drop}),
            32'(t[2:0]));
      end
      for (int j = 0; j < 4; j++) begin
         wr(pipc_pkg::OFS_MAC1, {4'h0, j[0], 3'h0});
         ctl[0] <= '{j[1], 1'b1, 1'b0, 1'b1, 1'b0};
         repeat (2) @(posedge pclk);
         #1;
         chk(32'({req[0].bp, req[0].pause}),
            32'({!j[1] && j[0], j[1]}));
      end
      fr(2, mk(14'h0080, 3'h1, 5'h00));
      chk(32'(dec[2].vld), 32'h1);
      ctl[0] <= '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
      l = 14'h0040 + 14'(seed[5:0]);
      wr(pipc_pkg::OFS_IRL, 8'h70);
      wr(pipc_pkg::OFS_PRIO0, 8'h01);
      wr(pipc_pkg::OFS_PRIO7, 8'h00);
      burst(mk(l, 3'h0, 5'h00), -1);
      wr(pipc_pkg::OFS_IRL, 8'h71);
      burst(mk(l, 3'h0, 5'h00), cnt(8'h71, 1, int'(l)));
      wr(pipc_pkg::OFS_PRIO0, 8'h02);
      burst(mk(l, 3'h0, 5'h00), cnt(8'h71, 1, int'(l)));
      apb(1'b0, ad(1, pipc_pkg::OFS_PRIO0), 8'h00);
      chk(rd, 32'h2);
      wr(pipc_pkg::OFS_PRIO7, 8'h00);
      burst(mk(l, 3'h0, 5'h00), cnt(8'h71, 2, int'(l)));
      wr(pipc_pkg::OFS_PRIO0, 8'h28);
      wr(pipc_pkg::OFS_PRIO7, 8'h00);
      wr(pipc_pkg::OFS_IRL, 8'h53);
      burst(mk(l, 3'h0, 5'h00), cnt(8'h53, 40, int'(l)));
      wr(pipc_pkg::OFS_IRL, 8'h50);
      burst(mk(l, 3'h0, 5'h00), cnt(8'h50, 40, int'(l)));
      wr(pipc_pkg::OFS_IRL, 8'h30);
      wr(pipc_pkg::OFS_PRIO0 + 12'h003, 8'h01);
      wr(pipc_pkg::OFS_PRIO7, 8'h00);
      burst(mk(l, 3'h3, 5'h00), cnt(8'h30, 1, int'(l)));
      wr(pipc_pkg::OFS_PRIO0, 8'h01);
      wr(pipc_pkg::OFS_PRIO7, 8'h00);
      for (int m = 0; m < 4; m++) begin
         wr(pipc_pkg::OFS_IRL, 8'h70 | 8'(m << 2));
         if (m > 0)
            repeat (20) fr(0, mk(l, 3'h0, CK[m-1]));
         burst(mk(l, 3'h0, CK[m]), cnt(8'h70, 1, int'(l)));
      end
      // Overrun without the limiter flow control bit: no request
      wr(pipc_pkg::OFS_IRL, 8'h60);
      repeat (70) fr(0, mk(l, 3'h0, 5'h00));
      chk(32'({dec[0].over, req[0].limit_fc}), 32'h2);
      // Frozen block: a frame is not taken and a read waits for pce
      pce <= 1'b0;
      fr(2, mk(14'h0080, 3'h1, 5'h00));
      chk(32'(dec[2].vld), 32'h0);
      fork
         apb(1'b0, ad(1, pipc_pkg::OFS_PRIO0), 8'h00);
         begin
            repeat (4) @(posedge pclk);
            pce <= 1'b1;
         end
      join
      chk(rd, 32'h1);
      tally_and_finish();
   end
endmodule // pipc_top_bench

bind pipc_top pipc_sva u_sva (.pclk(pclk), .presetn(presetn), .pce(pce),
   .psel(psel), .penable(penable), .paddr(paddr), .pslverr(pslverr),
   .pready(pready),
   .fc_filter(fc_filter), .frm(frm), .ctl(ctl), .dec(dec), .req(req));
